// File: src/motion_still_pkg.sv
// Purpose: Shared constants for the motion and stillness detector
// Assumes: Byte-wide register port, samples arrive at the output data rate
// Notes:   Offsets are byte addresses on the register port
package motion_still_pkg;
   // ------------------------------------------------------------------
   // Register map
   // ------------------------------------------------------------------
   localparam logic [7:0] MOTION_LIMIT_LOW_ADDR     = 8'h20;
   localparam logic [7:0] MOTION_LIMIT_HIGH_ADDR    = 8'h21;
   localparam logic [7:0] MOTION_DWELL_COUNT_ADDR   = 8'h22;
   localparam logic [7:0] STILLNESS_LIMIT_LOW_ADDR  = 8'h23;
   localparam logic [7:0] STILLNESS_LIMIT_HIGH_ADDR = 8'h24;
   localparam logic [7:0] STILLNESS_DWELL_LOW_ADDR  = 8'h25;
   localparam logic [7:0] STILLNESS_DWELL_HIGH_ADDR = 8'h26;
   localparam logic [7:0] MOTION_DETECT_CONFIG_ADDR = 8'h27;
   localparam logic [7:0] STATUS_ADDR               = 8'h0B;
   localparam int         REG_COUNT                 = 8;
   localparam int         REG_IDX_W                 = 3;
   localparam logic [7:0] REG_RESET                 = 8'h00;
   localparam logic [2:0] LIMIT_HIGH_MASK           = 3'h7;

   // ------------------------------------------------------------------
   // Field positions
   // ------------------------------------------------------------------
   localparam int CFG_MOTION_ON_BIT  = 0;
   localparam int CFG_MOTION_REL_BIT = 1;
   localparam int CFG_STILL_ON_BIT   = 2;
   localparam int CFG_STILL_REL_BIT  = 3;
   localparam int CFG_LINK_BIT       = 4;
   localparam int CFG_LOOP_BIT       = 5;
   localparam int STAT_MOTION_BIT    = 4;
   localparam int STAT_STILL_BIT     = 5;
   localparam int STAT_AWAKE_BIT     = 6;

   // ------------------------------------------------------------------
   // Widths and counts
   // ------------------------------------------------------------------
   localparam int SAMPLE_W = 12;
   localparam int LIMIT_W  = 11;
   localparam int MAG_W    = 13;
   localparam int AXES     = 3;
   localparam logic [8:0]  MOTION_ONE = 9'h001;
   localparam logic [16:0] STILL_ONE  = 17'h00001;

   typedef enum logic {ARM_MOTION, ARM_STILL} arm_t;
endpackage : motion_still_pkg

// File: src/motion_still_detector.sv
// Purpose: Motion and stillness event detection on three-axis samples
// Assumes: One sample set per SAMPLE_VALID_I pulse, inputs synchronous to clock
// Notes:   Status flags are cleared by a status read unless the loop pairing runs

module motion_still_detector
   import motion_still_pkg::*;
(
   input  wire logic                       CORE_CLK_I,
   input  wire logic                       RST_I,
   input  wire logic [7:0]                 REG_ADDR_I,
   input  wire logic [7:0]                 REG_WDATA_I,
   input  wire logic                       REG_WR_I,
   input  wire logic                       REG_RD_I,
   output logic      [7:0]                 REG_RDATA_O,
   input  wire logic                       SAMPLE_VALID_I,
   input  wire logic signed [SAMPLE_W-1:0] SAMPLE_X_I,
   input  wire logic signed [SAMPLE_W-1:0] SAMPLE_Y_I,
   input  wire logic signed [SAMPLE_W-1:0] SAMPLE_Z_I,
   input  wire logic                       WAKEUP_MODE_I,
   output logic                            MOTION_FLAG_O,
   output logic                            STILL_FLAG_O,
   output logic                            AWAKE_O
);
   // ------------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------------
   function automatic logic [MAG_W-1:0] magnitude(input logic signed [SAMPLE_W-1:0] s,
                                                  input logic signed [SAMPLE_W-1:0] r,
                                                  input logic                       rel);
      logic signed [MAG_W-1:0] d;
      d = rel ? ({s[SAMPLE_W-1], s} - {r[SAMPLE_W-1], r}) : {s[SAMPLE_W-1], s};
      magnitude = d[MAG_W-1] ? MAG_W'(-d) : MAG_W'(d);
   endfunction : magnitude

   function automatic logic reg_hit(input logic [7:0] addr, input logic [7:0] target);
      reg_hit = (addr == target);
   endfunction : reg_hit

   function automatic logic [REG_IDX_W-1:0] reg_slot(input logic [7:0] addr);
      reg_slot = REG_IDX_W'(addr - MOTION_LIMIT_LOW_ADDR);
   endfunction : reg_slot

   // ------------------------------------------------------------------
   // Register file
   // ------------------------------------------------------------------
   logic [7:0] regs_q [REG_COUNT];
   genvar gi;
   generate
      for (gi = 0; gi < REG_COUNT; gi++) begin : g_reg
         wire logic wr_hit = REG_WR_I &&
                             reg_hit(REG_ADDR_I, MOTION_LIMIT_LOW_ADDR + 8'(gi));
         always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
            if (RST_I) begin
               regs_q[gi] <= REG_RESET;
            end else if (wr_hit) begin
               regs_q[gi] <= REG_WDATA_I;
            end
         end
      end
   endgenerate

   wire logic [REG_IDX_W-1:0] rd_idx    = reg_slot(REG_ADDR_I);
   wire logic                 rd_in_map = (REG_ADDR_I >= MOTION_LIMIT_LOW_ADDR) &&
                                          (REG_ADDR_I <= MOTION_DETECT_CONFIG_ADDR);
   wire logic                 status_rd = REG_RD_I && reg_hit(REG_ADDR_I, STATUS_ADDR);

   // Limits and dwell counts, raw codes with no range scaling
   // Limit high bytes keep bits 7..3 for read back only
   wire logic [LIMIT_W-1:0] motion_limit =
      {regs_q[reg_slot(MOTION_LIMIT_HIGH_ADDR)][2:0] & LIMIT_HIGH_MASK,
       regs_q[reg_slot(MOTION_LIMIT_LOW_ADDR)]};
   wire logic [LIMIT_W-1:0] stillness_limit =
      {regs_q[reg_slot(STILLNESS_LIMIT_HIGH_ADDR)][2:0] & LIMIT_HIGH_MASK,
       regs_q[reg_slot(STILLNESS_LIMIT_LOW_ADDR)]};
   wire logic [7:0]  motion_dwell = regs_q[reg_slot(MOTION_DWELL_COUNT_ADDR)];
   wire logic [15:0] stillness_dwell =
      {regs_q[reg_slot(STILLNESS_DWELL_HIGH_ADDR)],
       regs_q[reg_slot(STILLNESS_DWELL_LOW_ADDR)]};
   wire logic [7:0]  cfg = regs_q[reg_slot(MOTION_DETECT_CONFIG_ADDR)];

   wire logic motion_detect_on      = cfg[CFG_MOTION_ON_BIT];
   wire logic motion_relative_sel   = cfg[CFG_MOTION_REL_BIT];
   wire logic stillness_detect_on   = cfg[CFG_STILL_ON_BIT];
   wire logic stillness_relative_sel = cfg[CFG_STILL_REL_BIT];
   wire logic paired = cfg[CFG_LINK_BIT] && motion_detect_on && stillness_detect_on;
   wire logic loop   = paired && cfg[CFG_LOOP_BIT];

   // ------------------------------------------------------------------
   // Arming and per-axis comparison
   // ------------------------------------------------------------------
   arm_t       arm_q;
   arm_t       arm_d;
   logic       m_need_q;
   logic       s_need_q;
   logic       m_event;
   logic       s_event;
   logic [AXES-1:0] over;
   logic [AXES-1:0] under;

   wire logic motion_active = motion_detect_on &&
                              (!paired || arm_q == ARM_MOTION);
   wire logic still_active  = stillness_detect_on &&
                              (!paired || arm_q == ARM_STILL);

   wire logic signed [SAMPLE_W-1:0] samp [AXES];
   assign samp[0] = SAMPLE_X_I;
   assign samp[1] = SAMPLE_Y_I;
   assign samp[2] = SAMPLE_Z_I;

   generate
      for (gi = 0; gi < AXES; gi++) begin : g_axis
         logic signed [SAMPLE_W-1:0] mref_q;
         logic signed [SAMPLE_W-1:0] sref_q;
         wire logic [MAG_W-1:0] m_mag = magnitude(samp[gi], mref_q, motion_relative_sel);
         wire logic [MAG_W-1:0] s_mag = magnitude(samp[gi], sref_q, stillness_relative_sel);
         assign over[gi]  = m_mag > {2'b00, motion_limit};
         assign under[gi] = s_mag < {2'b00, stillness_limit};
         // Reference taken from the first sample after arming
         always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
            if (RST_I) begin
               mref_q <= '0;
            end else if (SAMPLE_VALID_I && m_need_q) begin
               mref_q <= samp[gi];
            end
         end

         always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
            if (RST_I) begin
               sref_q <= '0;
            end else if (SAMPLE_VALID_I && s_need_q) begin
               sref_q <= samp[gi];
            end
         end
      end
   endgenerate

   // ------------------------------------------------------------------
   // Consecutive-sample counters
   // ------------------------------------------------------------------
   logic [7:0]  m_cnt_q;
   logic [15:0] s_cnt_q;

   // Reference capture sample is not judged, it would compare against the old reference
   wire logic m_qual = SAMPLE_VALID_I && motion_active &&
                       !(motion_relative_sel && m_need_q) && (|over);
   wire logic s_qual = SAMPLE_VALID_I && still_active &&
                       !(stillness_relative_sel && s_need_q) && (&under);
   wire logic m_fail = SAMPLE_VALID_I && !m_qual;
   wire logic s_fail = SAMPLE_VALID_I && !s_qual;

   wire logic [8:0]  m_cnt_next = {1'b0, m_cnt_q} + MOTION_ONE;
   wire logic [16:0] s_cnt_next = {1'b0, s_cnt_q} + STILL_ONE;
   wire logic [8:0]  m_target   = (WAKEUP_MODE_I || motion_dwell == 8'h00) ?
                                  MOTION_ONE : {1'b0, motion_dwell};
   wire logic [16:0] s_target   = (stillness_dwell == 16'h0000) ?
                                  STILL_ONE : {1'b0, stillness_dwell};

   assign m_event = m_qual && (m_cnt_next >= m_target);
   assign s_event = s_qual && (s_cnt_next >= s_target);

   wire logic [7:0]  m_cnt_d = (!motion_active || m_event || m_fail) ? 8'h00 :
                               (m_qual ? m_cnt_next[7:0] : m_cnt_q);
   wire logic [15:0] s_cnt_d = (!still_active || s_event || s_fail) ? 16'h0000 :
                               (s_qual ? s_cnt_next[15:0] : s_cnt_q);
   wire logic m_need_d = (!motion_active || m_event) ? 1'b1 :
                         (SAMPLE_VALID_I ? 1'b0 : m_need_q);
   wire logic s_need_d = (!still_active || s_event) ? 1'b1 :
                         (SAMPLE_VALID_I ? 1'b0 : s_need_q);

   // Alternation is immediate, a host read only clears flags
   always_comb begin
      arm_d = arm_q;
      if (!paired) begin
         arm_d = ARM_MOTION;
      end else if (m_event) begin
         arm_d = ARM_STILL;
      end else if (s_event) begin
         arm_d = ARM_MOTION;
      end
   end

   // ------------------------------------------------------------------
   // Status flags and read data
   // ------------------------------------------------------------------
   // Set wins over a clear in the same cycle so no event is lost
   wire logic host_clr = status_rd && !loop;
   // Loop pairing: each event retires the other flag
   wire logic m_flag_d = m_event ||
                         (MOTION_FLAG_O && !(host_clr || (loop && s_event)));
   wire logic s_flag_d = s_event ||
                         (STILL_FLAG_O && !(host_clr || (loop && m_event)));
   wire logic awake_d  = !paired ? 1'b1 :
                         (m_event ? 1'b1 : (s_event ? 1'b0 : AWAKE_O));

   logic [7:0] status_byte;
   always_comb begin
      status_byte                  = 8'h00;
      status_byte[STAT_MOTION_BIT] = MOTION_FLAG_O;
      status_byte[STAT_STILL_BIT]  = STILL_FLAG_O;
      status_byte[STAT_AWAKE_BIT]  = AWAKE_O;
   end

   wire logic [7:0] rdata_d = !REG_RD_I ? REG_RDATA_O :
                              (status_rd ? status_byte :
                              (rd_in_map ? regs_q[rd_idx] : 8'h00));

   // ------------------------------------------------------------------
   // State and output registers
   // ------------------------------------------------------------------
   always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
      if (RST_I) begin
         arm_q <= ARM_MOTION;
      end else begin
         arm_q <= arm_d;
      end
   end

   always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
      if (RST_I) begin
         m_need_q <= 1'b1;
      end else begin
         m_need_q <= m_need_d;
      end
   end

   always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
      if (RST_I) begin
         s_need_q <= 1'b1;
      end else begin
         s_need_q <= s_need_d;
      end
   end

   always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
      if (RST_I) begin
         m_cnt_q <= 8'h00;
      end else begin
         m_cnt_q <= m_cnt_d;
      end
   end

   always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
      if (RST_I) begin
         s_cnt_q <= 16'h0000;
      end else begin
         s_cnt_q <= s_cnt_d;
      end
   end

   always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
      if (RST_I) begin
         MOTION_FLAG_O <= 1'b0;
      end else begin
         MOTION_FLAG_O <= m_flag_d;
      end
   end

   always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
      if (RST_I) begin
         STILL_FLAG_O <= 1'b0;
      end else begin
         STILL_FLAG_O <= s_flag_d;
      end
   end

   // Unpaired operation reports awake, so reset leaves it high
   always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
      if (RST_I) begin
         AWAKE_O <= 1'b1;
      end else begin
         AWAKE_O <= awake_d;
      end
   end

   always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
      if (RST_I) begin
         REG_RDATA_O <= 8'h00;
      end else begin
         REG_RDATA_O <= rdata_d;
      end
   end
endmodule : motion_still_detector

// File: verification/motion_still_checker.sv
// Purpose: Port-level assertions for the motion and stillness detector
// Assumes: Register strobes and sample strobes are single-cycle pulses
// Notes:   Flag and awake changes are tied to their causes at the inputs
module motion_still_checker
   import motion_still_pkg::*;
(
   input wire logic                       CORE_CLK_I,
   input wire logic                       RST_I,
   input wire logic [7:0]                 REG_ADDR_I,
   input wire logic [7:0]                 REG_WDATA_I,
   input wire logic                       REG_WR_I,
   input wire logic                       REG_RD_I,
   input wire logic [7:0]                 REG_RDATA_O,
   input wire logic                       SAMPLE_VALID_I,
   input wire logic signed [SAMPLE_W-1:0] SAMPLE_X_I,
   input wire logic signed [SAMPLE_W-1:0] SAMPLE_Y_I,
   input wire logic signed [SAMPLE_W-1:0] SAMPLE_Z_I,
   input wire logic                       WAKEUP_MODE_I,
   input wire logic                       MOTION_FLAG_O,
   input wire logic                       STILL_FLAG_O,
   input wire logic                       AWAKE_O
);
   timeunit 1ns;
   timeprecision 100ps;
   logic in_map;
   logic stat_rd;
   assign in_map  = REG_ADDR_I inside {[8'h20:8'h27]};
   assign stat_rd = REG_RD_I && REG_ADDR_I == STATUS_ADDR;
   default clocking cb @(posedge CORE_CLK_I);
   endclocking
   default disable iff (RST_I);
   sequence s_write;
      REG_WR_I && !REG_RD_I && in_map;
   endsequence
   sequence s_read_same;
      REG_RD_I && !REG_WR_I && REG_ADDR_I == $past(REG_ADDR_I, 2);
   endsequence
   a_reg_read_back: assert property (s_write ##1 !REG_WR_I ##1 s_read_same |=>
      REG_RDATA_O == $past(REG_WDATA_I, 3)) else $error("register read back differs");
   a_unmapped_zero: assert property (REG_RD_I && !in_map && !stat_rd |=>
      REG_RDATA_O == 8'h00) else $error("unmapped read not zero");
   a_status_layout: assert property (stat_rd |=> REG_RDATA_O ==
      {1'b0, $past(AWAKE_O), $past(STILL_FLAG_O), $past(MOTION_FLAG_O), 4'h0})
      else $error("status read layout wrong");
   a_rdata_holds: assert property (!REG_RD_I |=> $stable(REG_RDATA_O))
      else $error("read data changed without a read");
   a_motion_cause: assert property ($rose(MOTION_FLAG_O) |-> $past(SAMPLE_VALID_I))
      else $error("motion flag rose without a sample");
   a_still_cause: assert property (!SAMPLE_VALID_I |=> !$rose(STILL_FLAG_O))
      else $error("stillness flag rose without a sample");
   a_motion_sticky: assert property ($fell(MOTION_FLAG_O) |->
      $past(stat_rd) || $rose(STILL_FLAG_O)) else $error("motion flag lost");
   a_still_sticky: assert property ($fell(STILL_FLAG_O) |->
      $past(stat_rd) || $rose(MOTION_FLAG_O)) else $error("stillness flag lost");
   a_awake_cause: assert property ($changed(AWAKE_O) |-> $past(SAMPLE_VALID_I) ||
      $past(REG_WR_I) || $past(REG_WR_I, 2)) else $error("awake changed without cause");
endmodule : motion_still_checker

bind motion_still_detector motion_still_checker i_chk (
   .CORE_CLK_I(CORE_CLK_I), .RST_I(RST_I), .REG_ADDR_I(REG_ADDR_I),
   .REG_WDATA_I(REG_WDATA_I), .REG_WR_I(REG_WR_I), .REG_RD_I(REG_RD_I),
   .REG_RDATA_O(REG_RDATA_O), .SAMPLE_VALID_I(SAMPLE_VALID_I), .SAMPLE_X_I(SAMPLE_X_I),
   .SAMPLE_Y_I(SAMPLE_Y_I), .SAMPLE_Z_I(SAMPLE_Z_I), .WAKEUP_MODE_I(WAKEUP_MODE_I),
   .MOTION_FLAG_O(MOTION_FLAG_O), .STILL_FLAG_O(STILL_FLAG_O), .AWAKE_O(AWAKE_O));

// File: verification/motion_host.sv
// Purpose: Host model that owns the register port of the detector
// Assumes: Strobes change 1 ns after the rising clock edge
// Notes:   Read data is taken one cycle after the strobe edge
module motion_host (
   input  wire logic       clk_i,
   input  wire logic [7:0] rdata_i,
   output logic      [7:0] addr_o,
   output logic      [7:0] wdata_o,
   output logic            wr_o,
   output logic            rd_o
);
   timeunit 1ns;
   timeprecision 100ps;
   initial begin
      addr_o  = 8'h00;
      wdata_o = 8'h00;
      wr_o    = 1'b0;
      rd_o    = 1'b0;
   end
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_i);
      #1;
      addr_o  = a;
      wdata_o = d;
      wr_o    = 1'b1;
      @(posedge clk_i);
      #1;
      wr_o    = 1'b0;
      wdata_o = ~d;
   endtask : wr
   // Status reads double as the host acknowledge
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk_i);
      #1;
      addr_o = a;
      rd_o   = 1'b1;
      @(posedge clk_i);
      #1;
      rd_o = 1'b0;
      d    = rdata_i;
   endtask : rd
endmodule : motion_host

// File: verification/tb.sv
// Purpose: Self-checking bench for the motion and stillness detector
// Assumes: Host model drives registers, bench drives samples
// Notes:   Flag view fl is {awake, stillness, motion} in bits 2..0
module tb
   import motion_still_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   logic                clk, rst, wr, rd, valid, wake, mflag, sflag, awake;
   logic [7:0]          addr, wdata, rdata, v;
   logic [SAMPLE_W-1:0] sx, sy, sz;
   int                  fails, comparisons;
   wire logic [7:0]     fl = {5'h00, awake, sflag, mflag};
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   motion_still_detector i_dut (.CORE_CLK_I(clk), .RST_I(rst), .REG_ADDR_I(addr),
      .REG_WDATA_I(wdata), .REG_WR_I(wr), .REG_RD_I(rd), .REG_RDATA_O(rdata),
      .SAMPLE_VALID_I(valid), .SAMPLE_X_I(sx), .SAMPLE_Y_I(sy), .SAMPLE_Z_I(sz),
      .WAKEUP_MODE_I(wake), .MOTION_FLAG_O(mflag), .STILL_FLAG_O(sflag), .AWAKE_O(awake));
   motion_host i_host (.clk_i(clk), .rdata_i(rdata), .addr_o(addr), .wdata_o(wdata),
      .wr_o(wr), .rd_o(rd));
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      comparisons++;
      if (seen !== exp) begin
         fails++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
      i_host.rd(a, v);
      chk(v, exp);
   endtask : rdchk
   task automatic smp(input int x, input int y, input int z);
      @(posedge clk);
      #1;
      {sx, sy, sz} = {x[SAMPLE_W-1:0], y[SAMPLE_W-1:0], z[SAMPLE_W-1:0]};
      valid = 1'b1;
      @(posedge clk);
      #1;
      valid = 1'b0;
      {sx, sy, sz} = ~{sx, sy, sz};
   endtask : smp
   task automatic report_and_stop;
      $display("comparisons %0d, fails %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : report_and_stop
   // Hang guard: bounded wait, counts as a mismatch
   initial begin
      repeat (20000) @(posedge clk);
      fails++;
      report_and_stop();
   end
   // ------------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------------
   initial begin
      {fails, comparisons} = '0;
      {rst, valid, wake, sx, sy, sz} = {1'b1, 2'b00, 36'h0};
      repeat (10) @(posedge clk);
      #1;
      rst = 1'b0;
      for (int i = 0; i < REG_COUNT; i++) rdchk(8'h20 + 8'(i), REG_RESET);
      rdchk(STATUS_ADDR, 8'h40);
      i_host.wr(8'h21, 8'hF9);
      rdchk(8'h21, 8'hF9);
      rdchk(8'h30, 8'h00);
      i_host.wr(8'h20, 8'h2C);
      i_host.wr(8'h27, 8'h01);
      smp(300, 0, 0);
      chk(fl, 8'h04);
      smp(0, -301, 0);
      chk(fl, 8'h05);
      rdchk(STATUS_ADDR, 8'h50);
      rdchk(STATUS_ADDR, 8'h40);
      i_host.wr(8'h22, 8'h03);
      repeat (2) smp(0, 0, 400);
      smp(0, 0, 0);
      repeat (2) smp(0, 0, 400);
      chk(fl, 8'h04);
      smp(0, 0, 400);
      chk(fl, 8'h05);
      rdchk(STATUS_ADDR, 8'h50);
      wake = 1'b1;
      smp(-500, 0, 0);
      chk(fl, 8'h05);
      wake = 1'b0;
      rdchk(STATUS_ADDR, 8'h50);
      i_host.wr(8'h27, 8'h04);
      i_host.wr(8'h23, 8'h0A);
      i_host.wr(8'h24, 8'hF9);
      i_host.wr(8'h25, 8'h02);
      i_host.wr(8'h26, 8'h01);
      repeat (257) smp(200, -265, 0);
      chk(fl, 8'h04);
      smp(0, 0, 265);
      chk(fl, 8'h06);
      rdchk(STATUS_ADDR, 8'h60);
      i_host.wr(8'h25, 8'h00);
      i_host.wr(8'h26, 8'h00);
      i_host.wr(8'h22, 8'h00);
      i_host.wr(8'h27, 8'h35);
      smp(0, 0, 0);
      chk(fl & 8'h03, 8'h00);
      smp(600, 0, 0);
      chk(fl, 8'h05);
      smp(0, 0, 0);
      chk(fl, 8'h02);
      rdchk(STATUS_ADDR, 8'h20);
      chk(fl, 8'h02);
      i_host.wr(8'h27, 8'h31);
      @(posedge clk);
      #1;
      chk(fl, 8'h06);
      rdchk(STATUS_ADDR, 8'h60);
      i_host.wr(8'h27, 8'h00);
      i_host.wr(8'h27, 8'h03);
      smp(1000, 0, 0);
      chk(fl, 8'h04);
      smp(1200, 0, 0);
      chk(fl, 8'h04);
      smp(1400, 0, 0);
      chk(fl, 8'h05);
      i_host.wr(8'h27, 8'h00);
      i_host.wr(8'h27, 8'h15);
      smp(600, 0, 0);
      rdchk(STATUS_ADDR, 8'h50);
      chk(fl, 8'h04);
      smp(0, 0, 0);
      chk(fl, 8'h02);
      i_host.wr(8'h27, 8'h00);
      rdchk(STATUS_ADDR, 8'h60);
      i_host.wr(8'h27, 8'h0C);
      smp(1500, 0, 0);
      chk(fl, 8'h04);
      smp(1600, 100, 0);
      chk(fl, 8'h06);
      report_and_stop();
   end
endmodule : tb
